// >>> hdl/spi_iso_pkg.sv
// Purpose: Shared constants and types of the isolated SPI select router
// Assumes: System clock mclk at 25 MHz
// Notes: Times are in ns; cycle counts are derived from them here

package spi_iso_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 40;
  // Glitch filter minimum pulse width, rounded up to cycles
  localparam int FILT_NS = 10;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  // Free-running static sample period, rounded down to cycles
  localparam int SAMPLE_NS = 1200;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  // Link watchdog timeout, rounded up to cycles
  localparam int WD_NS = 5000;
  localparam int WD_CYC = (WD_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Synchroniser input positions
  localparam int IN_CLK = 0;
  localparam int IN_FWD = 1;
  localparam int IN_RET = 2;
  localparam int IN_SEL = 3;
  localparam int IN_ALO = 4;
  localparam int IN_AHI = 5;
  localparam int IN_P1 = 6;
  localparam int IN_P2 = 7;
  localparam int N_IN = 8;
  // Channels that pass a glitch filter
  localparam int N_HS = 4;

  // ==========================================================
  // Static-level packet layout
  localparam int PKT_CLK = 0;
  localparam int PKT_FWD = 1;
  localparam int PKT_SEL = 2;
  localparam int PKT_ALO = 3;
  localparam int PKT_AHI = 4;
  localparam int PKT_W = 5;

  // ==========================================================
  // Routing and buffering
  localparam int N_ROUTE = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] ROUTE_RST = 2'h0;
  localparam logic HI_IMMUNITY_DEF = 1'b0;

  typedef enum logic {
    LK_IDLE = 1'b0,
    LK_SHIFT = 1'b1
  } link_st_e;

endpackage

// >>> hdl/sample_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes: Depth must be a power of two; storage is not reset

`timescale 1ns/100ps
`default_nettype none

module sample_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty_w = (wr_ptr_r == rd_ptr_r);
  wire push_w = in_valid && !full_w;
  wire pop_w = out_ready && !empty_w;

  // Handshake flags straight from the pointers
  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  // Pointer update; extra MSB tells full from empty
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Write port
  always_ff @(posedge mclk) begin
    if (push_w) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/spi_isolator_select_mux.sv
// Purpose: Digital model of an isolated SPI path with a routed select
// Assumes: All pins are asynchronous to mclk and are synchronised first
// Notes: Tristate pins appear as value plus output enable

`timescale 1ns/100ps
`default_nettype none

// Function
// - Any side unpowered puts every data output on both sides in high impedance.
// - Powered, each fast input is copied to its paired output.
// - No locking to the SPI clock; polarity, phase and timing pass unchanged.
// - Returned data output is always driven while powered, select or not.
// - Low-delay grade has no clock or data filter; a lost edge is fixed later.
// - High-immunity grade filters clock and both data channels, adding delay.
// - Select path is always glitch filtered in both grades.
// - Main select goes to exactly one of four routed outputs.
// - Address lines form a binary index; that output follows main select.
// - Unaddressed select outputs float; external pulls set their level.
// - Static levels sampled together, packed, shifted across; address feeds router.
// - Address sampled by a free-running clock; effect after bounded delay.
// - Two matching address samples are needed before the route changes.
// - Route change hands over cleanly without transients on other outputs.
// - Sampled fast levels checked internally; nothing shown outside.
// - Periodic refresh packets carry current input state to keep levels right.
// - No packets for about 5 us makes far-side outputs float.
module spi_isolator_select_mux
  import spi_iso_pkg::*;
#(
  parameter logic HI_IMMUNITY = HI_IMMUNITY_DEF,
  parameter int FILT_MIN = FILT_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic side1_supply,
  input wire logic side2_supply,
  input wire logic spi_clk_in,
  input wire logic fwd_data_in,
  input wire logic sub_data_in,
  input wire logic main_select_n,
  input wire logic route_addr_lo,
  input wire logic route_addr_hi,
  output logic ret_data_out,
  output logic ret_data_oe,
  output logic sub_clk_out,
  output logic sub_clk_oe,
  output logic sub_data_out,
  output logic sub_data_oe,
  output logic [N_ROUTE-1:0] routed_select_out,
  output logic [N_ROUTE-1:0] routed_select_oe
);

  localparam int CW = $clog2(FILT_MIN + 1);
  localparam int WDW = $clog2(WD_CYC + 1);
  localparam int SCW = $clog2(SAMPLE_CYC);
  localparam int SAMP_D = SAMPLE_CYC - 1;
  localparam int LNK_D = PKT_W + 1;

  // One-hot decode of a route index
  function automatic logic [N_ROUTE-1:0] route_dec(input logic [1:0] idx);
    route_dec = '0;
    route_dec[idx] = 1'b1;
  endfunction

  // ==========================================================
  // Input synchronisers
  // Every pin passes two flops; only the second is read
  wire [N_IN-1:0] in_raw = {side2_supply, side1_supply, route_addr_hi, route_addr_lo,
                            main_select_n, sub_data_in, fwd_data_in, spi_clk_in};
  logic [N_IN-1:0] s1_r;
  logic [N_IN-1:0] s2_r;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= in_raw;
      s2_r <= s1_r;
    end
  end

  // Both supplies must be present for any output to drive
  wire pwr_ok = s2_r[IN_P1] && s2_r[IN_P2];

  // ==========================================================
  // Glitch filters
  // Levels are passed as sampled, never retimed to the SPI clock
  wire [N_HS-1:0] filt;

  for (genvar i = 0; i < N_HS; i++) begin : g_flt
    logic q_r;
    logic [CW-1:0] cnt_r;
    wire differ = (s2_r[i] != q_r);
    // Select is always filtered; fast data only in high-immunity grade
    wire use_flt = (i == IN_SEL) || HI_IMMUNITY;
    // Bypass takes a new level at once, so even a one-cycle pulse passes
    wire take = differ && (!use_flt || (cnt_r == CW'(FILT_MIN - 1)));
    assign filt[i] = q_r;

    // New level must persist FILT_MIN cycles before it is accepted
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        q_r <= 1'b0;
        cnt_r <= '0;
      end else if (!differ || take) begin
        cnt_r <= '0;
        q_r <= take ? s2_r[i] : q_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Static-level sampler
  // Free-running tick; a failed level check asks for an early resample
  logic [SCW-1:0] samp_cnt_r;
  logic pend_r;
  logic [PKT_W-1:0] pkt_r;
  logic dc_bad_r;
  wire tick = (samp_cnt_r == SCW'(SAMPLE_CYC - 1));
  wire take_smp = (tick || dc_bad_r) && s2_r[IN_P1];
  wire fifo_in_ready;
  wire push = pend_r && fifo_in_ready;
  // A new sample wins over the clear of the pending flag
  wire pend_nxt = take_smp || (pend_r && !push);
  wire [PKT_W-1:0] pkt_nxt = {s2_r[IN_AHI], s2_r[IN_ALO], filt[IN_SEL],
                              filt[IN_FWD], filt[IN_CLK]};

  // Sample counter runs regardless of link state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      samp_cnt_r <= '0;
    end else begin
      samp_cnt_r <= tick ? '0 : samp_cnt_r + 1'b1;
    end
  end

  // All side-1 levels caught in the same cycle; held while back-pressured
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pend_r <= 1'b0;
      pkt_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      if (take_smp && !(pend_r && !push)) begin
        pkt_r <= pkt_nxt;
      end
    end
  end

  // ==========================================================
  // Packet buffer
  // Fills when side 2 is down; the sampler then waits on in_ready
  wire fifo_out_valid;
  wire [PKT_W-1:0] fifo_dout;
  link_st_e lk_st_r;
  wire fifo_pop = fifo_out_valid && (lk_st_r == LK_IDLE) && s2_r[IN_P2];

  sample_fifo #(
    .W(PKT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(pend_r),
    .in_ready(fifo_in_ready),
    .in_data(pkt_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_dout)
  );

  // ==========================================================
  // Slow serial link across the barrier
  // One bit per cycle, LSB first; rx word complete with pkt_vld_r
  logic [PKT_W-1:0] tx_r;
  logic [PKT_W-1:0] rx_r;
  logic [2:0] bit_cnt_r;
  logic pkt_vld_r;
  wire last_bit = (bit_cnt_r == 3'(PKT_W - 1));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lk_st_r <= LK_IDLE;
      tx_r <= '0;
      rx_r <= '0;
      bit_cnt_r <= '0;
      pkt_vld_r <= 1'b0;
    end else begin
      pkt_vld_r <= 1'b0;
      unique case (lk_st_r)
        LK_IDLE: begin
          if (fifo_pop) begin
            tx_r <= fifo_dout;
            bit_cnt_r <= '0;
            lk_st_r <= LK_SHIFT;
          end
        end
        LK_SHIFT: begin
          tx_r <= tx_r >> 1;
          rx_r <= {tx_r[0], rx_r[PKT_W-1:1]};
          bit_cnt_r <= bit_cnt_r + 1'b1;
          if (last_bit) begin
            pkt_vld_r <= 1'b1;
            lk_st_r <= LK_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Watchdog and level check on side 2
  // Starts expired so no side-2 output drives before the first packet
  logic [WDW-1:0] wd_cnt_r;
  wire alive = (wd_cnt_r != WDW'(WD_CYC));
  wire side2_on = pwr_ok && alive;
  wire dc_miss = (rx_r[PKT_CLK] != sub_clk_out) || (rx_r[PKT_FWD] != sub_data_out);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wd_cnt_r <= WDW'(WD_CYC);
    end else if (pkt_vld_r) begin
      wd_cnt_r <= '0;
    end else if (alive) begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // Internal only: a mismatch just triggers a fresh sample
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dc_bad_r <= 1'b0;
    end else begin
      dc_bad_r <= pkt_vld_r && dc_miss && side2_on;
    end
  end

  // ==========================================================
  // Route control
  // Route moves only after two equal address samples in a row
  logic [1:0] addr_prev_r;
  logic [1:0] route_r;
  wire [1:0] pkt_addr = {rx_r[PKT_AHI], rx_r[PKT_ALO]};

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr_prev_r <= ROUTE_RST;
      route_r <= ROUTE_RST;
    end else if (pkt_vld_r) begin
      addr_prev_r <= pkt_addr;
      if (pkt_addr == addr_prev_r) begin
        route_r <= pkt_addr;
      end
    end
  end

  // ==========================================================
  // Output stage
  // Enables switch in one register, so handover has no overlap
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ret_data_out <= 1'b0;
      ret_data_oe <= 1'b0;
      sub_clk_out <= 1'b0;
      sub_clk_oe <= 1'b0;
      sub_data_out <= 1'b0;
      sub_data_oe <= 1'b0;
      routed_select_out <= '0;
      routed_select_oe <= '0;
    end else begin
      ret_data_out <= filt[IN_RET];
      sub_clk_out <= filt[IN_CLK];
      sub_data_out <= filt[IN_FWD];
      routed_select_out <= {N_ROUTE{filt[IN_SEL]}};
      ret_data_oe <= pwr_ok;
      sub_clk_oe <= side2_on;
      sub_data_oe <= side2_on;
      routed_select_oe <= side2_on ? route_dec(route_r) : '0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_pop;
    fifo_pop;
  endsequence

  sequence s_deliver;
    pkt_vld_r && (rx_r == $past(fifo_dout, LNK_D));
  endsequence

  power_off_z_a: assert property (
    !pwr_ok |=> !(ret_data_oe || sub_clk_oe || sub_data_oe || (|routed_select_oe)))
    else $error("output driven while a side is unpowered");

  ret_always_a: assert property (
    pwr_ok |=> ret_data_oe && (ret_data_out == $past(filt[IN_RET])))
    else $error("returned data not driven while powered");

  hs_follow_a: assert property (
    pwr_ok |=> (sub_clk_out == $past(filt[IN_CLK])) && (sub_data_out == $past(filt[IN_FWD])))
    else $error("forwarded level does not follow input");

  bypass_pass_a: assert property (
    !HI_IMMUNITY && (s2_r[IN_FWD] != filt[IN_FWD]) |=> filt[IN_FWD] == $past(s2_r[IN_FWD]))
    else $error("low-delay grade delayed a data edge");

  hs_filter_a: assert property (
    HI_IMMUNITY && $changed(filt[IN_CLK]) |-> $past(g_flt[IN_CLK].cnt_r) == CW'(FILT_MIN - 1))
    else $error("clock filter passed a short pulse");

  sel_filter_a: assert property (
    $changed(filt[IN_SEL]) |-> $past(g_flt[IN_SEL].cnt_r) == CW'(FILT_MIN - 1))
    else $error("select filter passed a short pulse");

  one_route_a: assert property (
    $onehot0(routed_select_oe))
    else $error("more than one select output enabled");

  route_index_a: assert property (
    (|routed_select_oe) |-> (routed_select_oe == route_dec($past(route_r)))
      && (routed_select_out == {N_ROUTE{$past(filt[IN_SEL])}}))
    else $error("enabled select output does not match address");

  two_samples_a: assert property (
    $changed(route_r) |-> $past(pkt_vld_r) && ($past(addr_prev_r) == route_r))
    else $error("route changed on a single sample");

  clean_hand_a: assert property (
    $changed(route_r) && side2_on |=> routed_select_oe == route_dec($past(route_r)))
    else $error("route handover not clean");

  link_shift_a: assert property (
    s_pop |-> ##LNK_D s_deliver)
    else $error("packet not delivered intact");

  sample_tick_a: assert property (
    tick |-> ##1 !tick ##SAMP_D tick)
    else $error("sample tick period wrong");

  watchdog_a: assert property (
    !alive |=> !sub_clk_oe && !sub_data_oe && (routed_select_oe == '0))
    else $error("far side drives after watchdog expiry");

endmodule

`default_nettype wire

// >>> sim/spi_far_model.sv
// Purpose: Subordinate side of the isolated SPI path, four devices
// Assumes: Select lines carry pull-ups; device data is echoed back
// Notes: An unselected return line floats, modelled as a toggling level

`timescale 1ns/100ps
`default_nettype none

module spi_far_model
  import spi_iso_pkg::*;
(
  input wire logic mclk,
  input wire logic sub_data_out,
  input wire logic sub_data_oe,
  input wire logic [N_ROUTE-1:0] routed_select_out,
  input wire logic [N_ROUTE-1:0] routed_select_oe,
  output var logic sub_data_in,
  output logic [N_ROUTE-1:0] sel_level
);
  // ==========================================================
  // Select wires
  // Floating selects rest high through the board pull-ups
  assign sel_level = (routed_select_out & routed_select_oe) | ~routed_select_oe;

  // ==========================================================
  // Returned data
  // A selected device echoes what it received; otherwise nobody drives
  // the line, so it must not look like a held value
  initial sub_data_in = 1'b0;
  always @(posedge mclk) begin
    if (sel_level != 4'hF && sub_data_oe) begin
      sub_data_in <= sub_data_out;
    end else begin
      sub_data_in <= ~sub_data_in;
    end
  end
endmodule

`default_nettype wire

// >>> sim/spi_isolator_select_mux_tb.sv
// Purpose: Self-checking bench of the isolated SPI select router
// Assumes: Inputs change at the falling edge of mclk
// Notes: Filter width raised to 3 cycles so that filtering shows

`timescale 1ns/100ps
`default_nettype none

module spi_isolator_select_mux_tb;
  import spi_iso_pkg::*;
  localparam int FM = 3;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic s1p = 1'b1;
  logic s2p = 1'b1;
  logic spi_clk = 1'b0;
  logic fwd = 1'b0;
  logic sel_n = 1'b1;
  logic alo = 1'b0;
  logic ahi = 1'b0;
  logic ret_out, ret_oe, sclk_out, sclk_oe, sdat_out, sdat_oe, hi_clk, sub_in;
  logic [3:0] rs_out, rs_oe, lvl;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  // ==========================================================
  // Clock, devices and timeout
  initial begin
    forever #20 mclk = ~mclk;
  end

  spi_isolator_select_mux #(.HI_IMMUNITY(1'b0), .FILT_MIN(FM)) i_spi_isolator_select_mux (
    .mclk(mclk), .rstn(rstn), .side1_supply(s1p), .side2_supply(s2p),
    .spi_clk_in(spi_clk), .fwd_data_in(fwd), .sub_data_in(sub_in),
    .main_select_n(sel_n), .route_addr_lo(alo), .route_addr_hi(ahi),
    .ret_data_out(ret_out), .ret_data_oe(ret_oe), .sub_clk_out(sclk_out),
    .sub_clk_oe(sclk_oe), .sub_data_out(sdat_out), .sub_data_oe(sdat_oe),
    .routed_select_out(rs_out), .routed_select_oe(rs_oe));

  // Second grade shares the inputs; only its clock output is watched
  spi_isolator_select_mux #(.HI_IMMUNITY(1'b1), .FILT_MIN(FM)) i_spi_isolator_select_mux_hi (
    .mclk(mclk), .rstn(rstn), .side1_supply(s1p), .side2_supply(s2p),
    .spi_clk_in(spi_clk), .fwd_data_in(fwd), .sub_data_in(sub_in),
    .main_select_n(sel_n), .route_addr_lo(alo), .route_addr_hi(ahi),
    .ret_data_out(), .ret_data_oe(), .sub_clk_out(hi_clk), .sub_clk_oe(),
    .sub_data_out(), .sub_data_oe(), .routed_select_out(), .routed_select_oe());

  spi_far_model i_spi_far_model (
    .mclk(mclk), .sub_data_out(sdat_out), .sub_data_oe(sdat_oe),
    .routed_select_out(rs_out), .routed_select_oe(rs_oe),
    .sub_data_in(sub_in), .sel_level(lvl));

  // Ceiling well above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Move the route and wait for it; short limit means a timed check
  task automatic go_route(input logic [1:0] a, input int lim);
    int k;
    {ahi, alo} = a;
    for (k = 1; k < lim; k++) begin
      wt(1);
      if ($countones(rs_oe) > 1) check("route_overlap", rs_oe, 4'h0);
      if (rs_oe === 4'h1 << a) break;
    end
    check("route_oe", rs_oe, 4'h1 << a);
    if (lim < 200) begin
      check("route_min", 4'(k >= 30), 4'h1);
      check("route_max", 4'(k <= 80), 4'h1);
    end
    check("select_wires", lvl, sel_n ? 4'hF : ~(4'h1 << a));
    wt(100);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    wt(2);
    check("oe_reset", {1'b0, ret_oe, sclk_oe, sdat_oe} | rs_oe, 4'h0);
    rstn = 1'b1;
    go_route(2'h0, 200);
  endtask

  // Both levels through every fast channel, select held low meanwhile
  task automatic t_fast();
    sel_n = 1'b0;
    wt(10);
    for (int v = 1; v >= 0; v--) begin
      spi_clk = v[0];
      fwd = v[0];
      wt(4);
      check("sub_clk", 4'(sclk_out), 4'(v[0]));
      check("sub_data", 4'(sdat_out), 4'(v[0]));
      wt(5);
      check("ret_data", 4'(ret_out), 4'(v[0]));
    end
    sel_n = 1'b1;
    wt(20);
    check("ret_driven", 4'(ret_oe), 4'h1);
  endtask

  // One-cycle pulse passes the low-delay grade only
  task automatic t_glitch();
    spi_clk = 1'b1;
    wt(1);
    spi_clk = 1'b0;
    wt(3);
    check("pulse_seen", 4'(sclk_out), 4'h1);
    for (int i = 0; i < 8; i++) begin
      if (i == 2) spi_clk = 1'b1;
      if (i == 4) spi_clk = 1'b0;
      wt(1);
      check("hi_filtered", 4'(hi_clk), 4'h0);
    end
    spi_clk = 1'b1;
    wt(2 + FM);
    check("hi_early", 4'(hi_clk), 4'h0);
    wt(1);
    check("hi_passed", 4'(hi_clk), 4'h1);
    spi_clk = 1'b0;
    wt(10);
  endtask

  // Short select pulse is dropped, a held one arrives after the filter
  task automatic t_select();
    sel_n = 1'b0;
    wt(2);
    sel_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      wt(1);
      check("sel_glitch", rs_out, 4'hF);
    end
    sel_n = 1'b0;
    wt(2 + FM);
    check("sel_early", rs_out, 4'hF);
    wt(1);
    check("sel_follow", rs_out, 4'h0);
    check("sel_wire", lvl, 4'hE);
  endtask

  // Idle inputs must not let the far side time out
  task automatic t_refresh();
    for (int i = 0; i < 300; i++) begin
      wt(1);
      if (sclk_oe !== 1'b1) check("refresh", 4'(sclk_oe), 4'h1);
    end
    check("refresh_end", 4'(sclk_oe), 4'h1);
  endtask

  // Supplies dropped in turn; the link backs up while side 2 is off
  task automatic t_power();
    s2p = 1'b0;
    {ahi, alo} = 2'h2;
    wt(4);
    check("off2_data", {1'b0, ret_oe, sclk_oe, sdat_oe}, 4'h0);
    check("off2_sel", rs_oe, 4'h0);
    wt(400);
    s2p = 1'b1;
    go_route(2'h2, 700);
    s1p = 1'b0;
    wt(4);
    check("off1_data", {1'b0, ret_oe, sclk_oe, sdat_oe}, 4'h0);
    wt(WD_CYC + 30);
    // Side 1 back: power is fine, but until a packet arrives only the
    // expired watchdog keeps side 2 quiet
    s1p = 1'b1;
    wt(4);
    check("watchdog", rs_oe, 4'h0);
    check("wd_clk", 4'(sclk_oe), 4'h0);
    check("ret_back", 4'(ret_oe), 4'h1);
    go_route(2'h1, 400);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    t_reset();
    t_fast();
    t_glitch();
    t_select();
    go_route(2'h3, 100);
    go_route(2'h1, 100);
    go_route(2'h2, 100);
    go_route(2'h0, 100);
    t_refresh();
    t_power();
    conclude();
  end
endmodule

`default_nettype wire
